// ---- wlm_pkg.sv ----
// constants, encodings and decoding shared by the write latency config block
// assumes the 250 MHz core clock samples the command clock and pins
// Operation
// R01: a three-bit field selects write CAS latency 9,10,11,12,14,16 or 18.
// R02: the first write data bit is taken that latency after the write command.
// R03: all latencies are whole clock counts with no half-clock setting.
// R04: total write latency is additive plus parity plus write CAS latency.
// R05: a two-bit field picks normal, reduced, extended or automatic range.
// R06: a set write termination is applied during writes with no extra command.
// R07: in write leveling only the nominal termination is applied.
// R08: with write CRC on a write burst grows from eight to ten unit intervals.
// R09: with CRC and mask both on the controller sets 4 or 5 clocks extra.
// R10: the controller writes zero to every reserved mode register bit; the model clears only second register ones unless keepRsvd is set.
// R11: the 2-clock write preamble is used only at the two fastest grades.
// R12: decoded fields hold until overwritten by the same register or reset.
package wlm_pkg;
	// =========================================================
	// command bus
	localparam int MRS_ADDR_W = 18;
	localparam logic [2:0] SEL_MR1 = 3'h1;
	localparam logic [2:0] SEL_MR2 = 3'h2;
	localparam logic [2:0] SEL_MR3 = 3'h3;
	localparam logic [2:0] SEL_MR5 = 3'h5;
	// =========================================================
	// second mode register fields
	localparam int CWL_LSB = 3;
	localparam int LOW_POWER_SELFREFRESH_RANGE_LSB = 6;
	localparam int WTERM_LSB = 9;
	localparam int CRC_BIT = 12;
	localparam logic [17:0] MR2_RSVD_MASK = 18'h3E107;
	// first, third, fifth register fields
	localparam int NTERM_LSB = 8;
	localparam int WCL_LSB = 9;
	localparam int MASK_BIT = 10;
	localparam logic [2:0] TERM_OFF = 3'h0;
	// =========================================================
	// latencies
	localparam int LAT_W = 6;
	localparam logic [1:0] BURST_CLK_NORMAL = 2'h3;
	localparam logic [2:0] BURST_CLK_CRC_EXTRA = 3'h1;
	localparam logic [LAT_W-1:0] WCL_BASE = 6'h04;
	// =========================================================
	// apb map
	localparam logic [7:0] ADDR_LATCFG = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_MR2 = 8'h08;
	localparam int AL_LSB = 0;
	localparam int PL_LSB = 8;
	localparam logic [31:0] LATCFG_RESET = 32'h0000_0000;
	localparam logic [31:0] LATCFG_MASK = 32'h0000_0F1F;

	typedef enum logic [1:0] {
		WLM_RANGE_NORMAL,
		WLM_RANGE_REDUCED,
		WLM_RANGE_EXTENDED,
		WLM_RANGE_AUTO
	} wlm_range_e;

	// write CAS latency code to clocks, zero for the unused code
	function automatic logic [LAT_W-1:0] cwl_decode(input logic [2:0] code);
		case (code)
			3'h0: cwl_decode = 6'h09;
			3'h1: cwl_decode = 6'h0A;
			3'h2: cwl_decode = 6'h0B;
			3'h3: cwl_decode = 6'h0C;
			3'h4: cwl_decode = 6'h0E;
			3'h5: cwl_decode = 6'h10;
			3'h6: cwl_decode = 6'h12;
			default: cwl_decode = 6'h00;
		endcase
	endfunction : cwl_decode
endpackage : wlm_pkg

// ---- wlm_cfg_if.sv ----
// decoded configuration passed between the block's own modules
// assumes one clock domain on both sides
`timescale 1ns/1ps
`default_nettype none
interface wlm_cfg_if;
	logic [2:0] cwlCode;
	logic [4:0] additiveLatency;
	logic [3:0] parityLatency;
	logic crcEnable;
	logic [wlm_pkg::LAT_W-1:0] writeCasLatency;
	logic [wlm_pkg::LAT_W-1:0] totalWriteLatency;
	logic cwlValid;
	modport top (output cwlCode, additiveLatency, parityLatency, crcEnable,
		input writeCasLatency, totalWriteLatency, cwlValid);
	modport dec (input cwlCode, additiveLatency, parityLatency,
		output writeCasLatency, totalWriteLatency, cwlValid);
	modport tmr (input totalWriteLatency, crcEnable);
endinterface : wlm_cfg_if
`default_nettype wire

// ---- wlm_latency_dec.sv ----
// registered decode of write CAS latency and total write latency
// assumes fields are stable apart from mode register updates
`timescale 1ns/1ps
`default_nettype none
module wlm_latency_dec (
	// clock and reset
	input wire logic clock,
	input wire logic resetn,
	input wire logic clockEnable,
	// configuration
	wlm_cfg_if.dec cfg
);
	logic [wlm_pkg::LAT_W-1:0] next_cwl;

	always_comb begin
		next_cwl = wlm_pkg::cwl_decode(cfg.cwlCode); // R01 R03
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			cfg.writeCasLatency <= '0;
			cfg.totalWriteLatency <= '0;
			cfg.cwlValid <= 1'b0;
		end else if (clockEnable) begin
			cfg.writeCasLatency <= next_cwl;
			cfg.totalWriteLatency <= next_cwl
				+ wlm_pkg::LAT_W'(cfg.additiveLatency)
				+ wlm_pkg::LAT_W'(cfg.parityLatency); // R04
			cfg.cwlValid <= (next_cwl != '0);
		end
	end
endmodule : wlm_latency_dec
`default_nettype wire

// ---- wlm_write_timer.sv ----
// counts command clock edges from a write command to data capture
// assumes linkRise is a one-cycle pulse per command clock rising edge
`timescale 1ns/1ps
`default_nettype none
module wlm_write_timer (
	// clock and reset
	input wire logic clock,
	input wire logic resetn,
	input wire logic clockEnable,
	// events
	input wire logic linkRise,
	input wire logic writeCommand,
	// configuration
	wlm_cfg_if.tmr cfg,
	// status
	output logic dataAccept,
	output logic burstActive,
	output logic timerBusy
);
	logic [wlm_pkg::LAT_W-1:0] latCount;
	logic [2:0] burstCount;
	logic waiting;

	assign timerBusy = waiting || burstActive;

	// latency wait, a new write while busy is ignored
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			waiting <= 1'b0;
			latCount <= '0;
		end else if (clockEnable && linkRise) begin
			if (!waiting && !burstActive && writeCommand) begin
				waiting <= 1'b1;
				latCount <= cfg.totalWriteLatency - 6'h01; // R02 R04
			end else if (waiting && latCount == '0) begin
				waiting <= 1'b0;
			end else if (waiting) begin
				latCount <= latCount - 6'h01;
			end
		end
	end

	// data burst, 4 clocks or 5 with crc
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			dataAccept <= 1'b0;
			burstActive <= 1'b0;
			burstCount <= '0;
		end else if (clockEnable) begin
			dataAccept <= linkRise && waiting && latCount == '0; // R02
			if (linkRise && waiting && latCount == '0) begin
				burstActive <= 1'b1;
				burstCount <= {1'b0, wlm_pkg::BURST_CLK_NORMAL}
					+ (cfg.crcEnable ? wlm_pkg::BURST_CLK_CRC_EXTRA
					: 3'h0); // R08
			end else if (linkRise && burstActive) begin
				if (burstCount == '0) begin
					burstActive <= 1'b0;
				end else begin
					burstCount <= burstCount - 3'h1;
				end
			end
		end
	end
endmodule : wlm_write_timer
`default_nettype wire

// ---- wlm_write_latency_mode_config.sv ----
// mode register capture, termination select and apb view of write latency
// assumes pins are asynchronous to clock; apb master on clock
`timescale 1ns/1ps
`default_nettype none
module wlm_write_latency_mode_config (
	// clock and reset
	input wire logic clock,
	input wire logic resetn,
	input wire logic clockEnable,
	// command pins
	input wire logic commandClock,
	input wire logic modeRegisterSetCommand,
	input wire logic writeCommandPin,
	input wire logic [2:0] registerSelect,
	input wire logic [17:0] commandAddress,
	input wire logic writeLevelingMode,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// decoded outputs
	output logic [5:0] totalWriteLatency,
	output logic [5:0] writeCasLatency,
	output logic [1:0] lowPowerSelfrefreshRange,
	output logic [2:0] terminationSelect,
	output logic writeCrcEnable,
	output logic dataAccept,
	output logic burstActive,
	output logic reservedBitError
);
	// =========================================================
	// pin synchronisers
	localparam int PIN_W = 25;
	// bit positions of the sampled pins inside the synchroniser word
	localparam int PIN_CK = 24;
	localparam int PIN_MRS = 23;
	localparam int PIN_WR = 22;
	localparam int PIN_LVL = 21;
	localparam int PIN_SEL = 18;
	localparam int PIN_ADDR_W = 17;
	logic [PIN_W-1:0] pinMeta;
	logic [PIN_W-1:0] pinSync;
	logic ckLast;
	logic linkRise;
	logic mrsSeen;
	logic wrSeen;
	logic [2:0] selSeen;
	logic [17:0] addrSeen;
	logic levelSeen;

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			pinMeta <= '0;
			pinSync <= '0;
			ckLast <= 1'b0;
		end else if (clockEnable) begin
			pinMeta <= {commandClock, modeRegisterSetCommand, writeCommandPin,
				writeLevelingMode, registerSelect, commandAddress};
			pinSync <= pinMeta;
			ckLast <= pinSync[PIN_CK];
		end
	end

	assign linkRise = pinSync[PIN_CK] && !ckLast;
	assign mrsSeen = pinSync[PIN_MRS];
	assign wrSeen = pinSync[PIN_WR];
	assign levelSeen = pinSync[PIN_LVL];
	assign selSeen = pinSync[PIN_SEL +: 3];
	// the top address bit feeds no captured field
	assign addrSeen = {1'b0, pinSync[PIN_ADDR_W-1:0]};

	// =========================================================
	// mode register capture
	logic [17:0] mr2Shadow;
	logic [2:0] nominalTermination;
	logic [1:0] extraWriteCmdLatency;
	logic writeByteMask;
	logic mrsTake;

	assign mrsTake = clockEnable && linkRise && mrsSeen;

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			mr2Shadow <= '0;
		end else if (mrsTake && selSeen == wlm_pkg::SEL_MR2) begin
			mr2Shadow <= addrSeen; // R12
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			nominalTermination <= wlm_pkg::TERM_OFF;
			extraWriteCmdLatency <= '0;
			writeByteMask <= 1'b0;
		end else if (mrsTake) begin
			if (selSeen == wlm_pkg::SEL_MR1) begin
				nominalTermination <= addrSeen[wlm_pkg::NTERM_LSB +: 3];
			end
			if (selSeen == wlm_pkg::SEL_MR3) begin
				extraWriteCmdLatency <= addrSeen[wlm_pkg::WCL_LSB +: 2];
			end
			if (selSeen == wlm_pkg::SEL_MR5) begin
				writeByteMask <= addrSeen[wlm_pkg::MASK_BIT];
			end
		end
	end

	// sticky flag, a new violation wins over a clear
	logic rsvdClear;
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			reservedBitError <= 1'b0;
		end else if (clockEnable) begin
			if (mrsTake && selSeen == wlm_pkg::SEL_MR2
				&& |(addrSeen & wlm_pkg::MR2_RSVD_MASK)) begin
				reservedBitError <= 1'b1; // R10
			end else if (rsvdClear) begin
				reservedBitError <= 1'b0;
			end
		end
	end

	// =========================================================
	// latency decode and write timing
	wlm_cfg_if cfg ();
	logic [31:0] latCfg;
	logic timerBusy;

	assign cfg.cwlCode = mr2Shadow[wlm_pkg::CWL_LSB +: 3];
	assign cfg.additiveLatency = latCfg[wlm_pkg::AL_LSB +: 5];
	assign cfg.parityLatency = latCfg[wlm_pkg::PL_LSB +: 4];
	assign cfg.crcEnable = mr2Shadow[wlm_pkg::CRC_BIT];

	wlm_latency_dec u_dec (
		.clock(clock),
		.resetn(resetn),
		.clockEnable(clockEnable),
		.cfg(cfg.dec)
	);

	wlm_write_timer u_tmr (
		.clock(clock),
		.resetn(resetn),
		.clockEnable(clockEnable),
		.linkRise(linkRise),
		.writeCommand(wrSeen),
		.cfg(cfg.tmr),
		.dataAccept(dataAccept),
		.burstActive(burstActive),
		.timerBusy(timerBusy)
	);

	assign totalWriteLatency = cfg.totalWriteLatency;
	assign writeCasLatency = cfg.writeCasLatency;
	assign writeCrcEnable = cfg.crcEnable; // R08

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			lowPowerSelfrefreshRange <= 2'(wlm_pkg::WLM_RANGE_NORMAL);
		end else if (clockEnable) begin
			lowPowerSelfrefreshRange <= mr2Shadow[wlm_pkg::LOW_POWER_SELFREFRESH_RANGE_LSB +: 2]; // R05
		end
	end

	// =========================================================
	// termination select
	logic [2:0] writeTermination;
	assign writeTermination = mr2Shadow[wlm_pkg::WTERM_LSB +: 3];

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			terminationSelect <= wlm_pkg::TERM_OFF;
		end else if (clockEnable) begin
			if (levelSeen) begin
				terminationSelect <= nominalTermination; // R07
			end else if (timerBusy && writeTermination != wlm_pkg::TERM_OFF) begin
				terminationSelect <= writeTermination; // R06
			end else begin
				terminationSelect <= nominalTermination;
			end
		end
	end

	// =========================================================
	// apb slave, zero wait states
	logic apbWrite;
	logic apbRead;
	logic addrOk;
	assign pready = 1'b1;
	assign apbWrite = psel && penable && pwrite && clockEnable;
	assign apbRead = psel && !penable && !pwrite;
	assign addrOk = paddr == wlm_pkg::ADDR_LATCFG
		|| paddr == wlm_pkg::ADDR_STATUS || paddr == wlm_pkg::ADDR_MR2;
	assign pslverr = psel && penable && !addrOk;
	assign rsvdClear = apbWrite && paddr == wlm_pkg::ADDR_STATUS && pwdata[31];

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			latCfg <= wlm_pkg::LATCFG_RESET;
		end else if (apbWrite && paddr == wlm_pkg::ADDR_LATCFG) begin
			latCfg <= pwdata & wlm_pkg::LATCFG_MASK;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			prdata <= '0;
		end else if (clockEnable && apbRead) begin
			case (paddr)
				wlm_pkg::ADDR_LATCFG: prdata <= latCfg;
				wlm_pkg::ADDR_STATUS: prdata <= {reservedBitError,
					writeByteMask, 3'h0, extraWriteCmdLatency, 3'h0,
					nominalTermination, writeTermination,
					lowPowerSelfrefreshRange, cfg.crcEnable, cfg.cwlValid,
					cfg.totalWriteLatency, cfg.writeCasLatency};
				wlm_pkg::ADDR_MR2: prdata <= {14'h0, mr2Shadow};
				default: prdata <= '0;
			endcase
		end
	end

	// =========================================================
	// checks
	property p_cwl_map;
		@(posedge clock) disable iff (!resetn)
		clockEnable && $stable(mr2Shadow) |=> clockEnable |->
		writeCasLatency == wlm_pkg::cwl_decode($past(cfg.cwlCode));
	endproperty
	a_cwl_map: assert property (p_cwl_map) else $error("cwl decode wrong"); // R01
	property p_cwl_whole;
		@(posedge clock) disable iff (!resetn)
		cfg.cwlValid |-> writeCasLatency >= 6'h09 && writeCasLatency <= 6'h12;
	endproperty
	a_cwl_whole: assert property (p_cwl_whole) else $error("cwl range"); // R03
	property p_wl_sum;
		@(posedge clock) disable iff (!resetn)
		clockEnable ##1 clockEnable && $stable(latCfg) && $stable(mr2Shadow)
		|-> totalWriteLatency == writeCasLatency
			+ 6'(latCfg[4:0]) + 6'(latCfg[11:8]);
	endproperty
	a_wl_sum: assert property (p_wl_sum) else $error("wl sum wrong"); // R04
	property p_accept_burst;
		@(posedge clock) disable iff (!resetn)
		dataAccept |-> burstActive;
	endproperty
	a_accept_burst: assert property (p_accept_burst) else $error("no burst"); // R02
	property p_range;
		@(posedge clock) disable iff (!resetn)
		clockEnable |=> lowPowerSelfrefreshRange == $past(mr2Shadow[7:6]);
	endproperty
	a_range: assert property (p_range) else $error("range mismatch"); // R05
	property p_wterm;
		@(posedge clock) disable iff (!resetn)
		clockEnable && !levelSeen && timerBusy && writeTermination != 3'h0
		|=> terminationSelect == $past(writeTermination);
	endproperty
	a_wterm: assert property (p_wterm) else $error("write term missing"); // R06
	property p_level;
		@(posedge clock) disable iff (!resetn)
		clockEnable && levelSeen |=> terminationSelect == $past(nominalTermination);
	endproperty
	a_level: assert property (p_level) else $error("leveling term"); // R07
	property p_hold;
		@(posedge clock) disable iff (!resetn)
		!(mrsTake && selSeen == wlm_pkg::SEL_MR2) |=> $stable(mr2Shadow);
	endproperty
	a_hold: assert property (p_hold) else $error("mr2 changed"); // R12
	property p_crc;
		@(posedge clock) disable iff (!resetn)
		mrsTake && selSeen == wlm_pkg::SEL_MR2
		|=> writeCrcEnable == $past(addrSeen[wlm_pkg::CRC_BIT]);
	endproperty
	a_crc: assert property (p_crc) else $error("crc flag"); // R08
	// capture, sticky flag, idle termination and pulse width
	property p_mr2_take;
		@(posedge clock) disable iff (!resetn)
		mrsTake && selSeen == wlm_pkg::SEL_MR2 |=> mr2Shadow == $past(addrSeen);
	endproperty
	a_mr2_take: assert property (p_mr2_take) else $error("mr2 not taken"); // R12
	property p_rsvd_set;
		@(posedge clock) disable iff (!resetn)
		mrsTake && selSeen == wlm_pkg::SEL_MR2
		&& |(addrSeen & wlm_pkg::MR2_RSVD_MASK) |=> reservedBitError;
	endproperty
	a_rsvd_set: assert property (p_rsvd_set) else $error("reserved flag"); // R10
	property p_idle_term;
		@(posedge clock) disable iff (!resetn)
		clockEnable && !timerBusy |=> terminationSelect == $past(nominalTermination);
	endproperty
	a_idle_term: assert property (p_idle_term) else $error("idle term"); // R06
	property p_accept_pulse;
		@(posedge clock) disable iff (!resetn)
		dataAccept |=> !dataAccept;
	endproperty
	a_accept_pulse: assert property (p_accept_pulse) else $error("accept long"); // R02
	c_write: cover property (@(posedge clock) disable iff (!resetn) dataAccept);
	c_crc: cover property (@(posedge clock) disable iff (!resetn)
		dataAccept && writeCrcEnable);
	c_level: cover property (@(posedge clock) disable iff (!resetn)
		levelSeen && timerBusy);
	c_auto_range: cover property (@(posedge clock) disable iff (!resetn)
		lowPowerSelfrefreshRange == 2'(wlm_pkg::WLM_RANGE_AUTO));
	c_reserved: cover property (@(posedge clock) disable iff (!resetn)
		reservedBitError);
endmodule : wlm_write_latency_mode_config
`default_nettype wire

// ---- wlm_ctrl_model.sv ----
// controller model: drives the command pins of the write latency block
// assumes the command clock runs free at a 48 ns period
`timescale 1ns/1ps
`default_nettype none
module wlm_ctrl_model #(
	parameter logic [1:0] WCL_CODE = 2'h1
) (
	// command pins
	output logic commandClock,
	output logic modeRegisterSetCommand,
	output logic writeCommandPin,
	output logic [2:0] registerSelect,
	output logic [17:0] commandAddress
);
	int rises;

	initial begin
		commandClock = 1'b0;
		modeRegisterSetCommand = 1'b0;
		writeCommandPin = 1'b0;
		registerSelect = 3'h0;
		commandAddress = 18'h00000;
		rises = 0;
		#7;
		forever #24 commandClock = ~commandClock;
	end

	always @(posedge commandClock) begin
		rises <= rises + 1;
	end

	// =========================================================
	// command issue, whole command clocks only
	task automatic issue(input logic m, input logic w, input logic [2:0] sel,
		input logic [17:0] a);
		@(negedge commandClock);
		modeRegisterSetCommand <= m;
		writeCommandPin <= w;
		registerSelect <= sel;
		commandAddress <= a;
		@(negedge commandClock);
		modeRegisterSetCommand <= 1'b0;
		writeCommandPin <= 1'b0;
		// released bus no longer shows the old value
		registerSelect <= ~sel;
		commandAddress <= ~a;
	endtask : issue

	task automatic mode_register_set_command(input logic [2:0] sel, input logic [17:0] a,
		input bit keepRsvd);
		if (sel == wlm_pkg::SEL_MR2 && !keepRsvd) begin
			a = a & ~wlm_pkg::MR2_RSVD_MASK;
		end
		issue(1'b1, 1'b0, sel, a);
	endtask : mode_register_set_command
endmodule : wlm_ctrl_model
`default_nettype wire

// ---- wlm_write_latency_mode_config_tb_top.sv ----
// self-checking bench of the write latency mode config block
// assumes the controller model and the design package are compiled first
`timescale 1ns/1ps
`default_nettype none
module wlm_write_latency_mode_config_tb_top;
	logic clock, resetn, clockEnable, writeLevelingMode;
	logic psel, penable, pwrite, pready, pslverr, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd, d;
	logic [5:0] totalWriteLatency, writeCasLatency;
	logic [1:0] lowPowerSelfrefreshRange;
	logic [2:0] terminationSelect, regSel;
	logic writeCrcEnable, dataAccept, burstActive, reservedBitError;
	logic cmdClk, mrsCmd, wrCmd;
	logic [17:0] cmdAddr, lastMr2;
	int mismatches, num_checks, al, pl, write_cas_latency, rng, wt, crcOn, nt, n, cnt;
	int cwlTab[8] = '{9, 10, 11, 12, 14, 16, 18, 0};

	wlm_ctrl_model u_wlm_ctrl_model (.commandClock(cmdClk),
		.modeRegisterSetCommand(mrsCmd), .writeCommandPin(wrCmd),
		.registerSelect(regSel), .commandAddress(cmdAddr));

	wlm_write_latency_mode_config u_wlm_write_latency_mode_config (
		.clock(clock), .resetn(resetn), .clockEnable(clockEnable),
		.commandClock(cmdClk), .modeRegisterSetCommand(mrsCmd),
		.writeCommandPin(wrCmd), .registerSelect(regSel),
		.commandAddress(cmdAddr), .writeLevelingMode(writeLevelingMode),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.totalWriteLatency(totalWriteLatency),
		.writeCasLatency(writeCasLatency),
		.lowPowerSelfrefreshRange(lowPowerSelfrefreshRange),
		.terminationSelect(terminationSelect),
		.writeCrcEnable(writeCrcEnable), .dataAccept(dataAccept),
		.burstActive(burstActive), .reservedBitError(reservedBitError));

	always #2 clock = ~clock;

	// =========================================================
	// checking and closing
	task automatic check(input logic [31:0] seen, input logic [31:0] exp,
		input string what);
		num_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask : check

	task automatic conclude;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : conclude

	task automatic timeout(input string what);
		mismatches++;
		$display("ERROR %0t: wait for %s ran out", $time, what);
		conclude();
	endtask : timeout

	// =========================================================
	// apb transfer and mode register command
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] r, output logic e);
		int k;
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge clock);
		penable <= 1'b1;
		for (k = 0; k < 20; k++) begin
			@(posedge clock);
			if (pready === 1'b1) break;
		end
		if (k == 20) timeout("pready");
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic mrsw(input logic [2:0] sel, input logic [17:0] a, input bit ok);
		u_wlm_ctrl_model.mode_register_set_command(sel, a, ok);
		repeat (4) @(posedge clock);
	endtask : mrsw

	// write command, latency count, termination and burst length
	task automatic do_write(input bit lvl);
		int start;
		u_wlm_ctrl_model.issue(1'b0, 1'b1, 3'h0, 18'h00000);
		start = u_wlm_ctrl_model.rises;
		n = 0;
		while (dataAccept !== 1'b1) begin
			@(posedge clock);
			n++;
			if (n > 1000) timeout("dataAccept");
		end
		check(u_wlm_ctrl_model.rises - start, al + pl + write_cas_latency, "latency");
		check(terminationSelect, lvl ? nt : wt, "write term");
		cnt = 0;
		repeat (7) begin
			@(posedge cmdClk);
			if (burstActive === 1'b1) cnt++;
		end
		check(cnt, crcOn ? 5 : 4, "burst clocks");
		check(terminationSelect, nt, "idle term");
	endtask : do_write

	// =========================================================
	// main sequence
	initial begin
		clock = 1'b0;
		resetn = 1'b0;
		clockEnable = 1'b1;
		writeLevelingMode = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		mismatches = 0;
		num_checks = 0;
		void'($urandom(98947));
		repeat (6) @(posedge clock);
		check(totalWriteLatency, 32'h0, "wl reset");
		resetn <= 1'b1;
		@(posedge clock);
		apb(1'b0, wlm_pkg::ADDR_LATCFG, 32'h0, rd, err);
		check(rd, wlm_pkg::LATCFG_RESET, "cfg reset");
		$display("test reset done");
		d = $urandom;
		apb(1'b1, wlm_pkg::ADDR_LATCFG, d, rd, err);
		apb(1'b0, wlm_pkg::ADDR_LATCFG, 32'h0, rd, err);
		check(rd, d & wlm_pkg::LATCFG_MASK, "cfg readback");
		clockEnable <= 1'b0;
		apb(1'b1, wlm_pkg::ADDR_LATCFG, ~d, rd, err);
		clockEnable <= 1'b1;
		apb(1'b0, wlm_pkg::ADDR_LATCFG, 32'h0, rd, err);
		check(rd, d & wlm_pkg::LATCFG_MASK, "frozen write");
		apb(1'b1, 8'h0C, d, rd, err);
		check(err, 32'h1, "unmapped write");
		apb(1'b0, 8'h0C, 32'h0, rd, err);
		check({err, rd[30:0]}, 32'h80000000, "unmapped read");
		$display("test apb done");
		al = $urandom % 16;
		pl = $urandom % 8;
		apb(1'b1, wlm_pkg::ADDR_LATCFG, (pl << wlm_pkg::PL_LSB) | al, rd, err);
		nt = 5;
		mrsw(wlm_pkg::SEL_MR1, 18'(nt << wlm_pkg::NTERM_LSB), 1'b0);
		for (int code = 7; code >= 0; code--) begin
			rng = $urandom % 4;
			wt = 1 + $urandom % 4;
			crcOn = $urandom % 2;
			write_cas_latency = cwlTab[code];
			writeLevelingMode <= (code == 2);
			lastMr2 = 18'((code << wlm_pkg::CWL_LSB) | (rng << wlm_pkg::LOW_POWER_SELFREFRESH_RANGE_LSB)
				| (wt << wlm_pkg::WTERM_LSB) | (crcOn << wlm_pkg::CRC_BIT));
			mrsw(wlm_pkg::SEL_MR2, lastMr2, 1'b0);
			check(writeCasLatency, write_cas_latency, "cwl");
			check(totalWriteLatency, al + pl + write_cas_latency, "total wl");
			check(lowPowerSelfrefreshRange, rng, "range");
			check(writeCrcEnable, crcOn, "crc");
			apb(1'b0, wlm_pkg::ADDR_STATUS, 32'h0, rd, err);
			check(rd[15:0], {rng[1:0], crcOn[0], code != 7, 6'(al + pl + write_cas_latency),
				6'(write_cas_latency)}, "status");
			if (code < 7) do_write(code == 2);
			$display("test write code %0d done", code);
		end
		writeLevelingMode <= 1'b0;
		mrsw(wlm_pkg::SEL_MR3, 18'(u_wlm_ctrl_model.WCL_CODE) << wlm_pkg::WCL_LSB, 1'b0);
		check(writeCasLatency, 32'd9, "cwl held");
		apb(1'b0, wlm_pkg::ADDR_STATUS, 32'h0, rd, err);
		check(rd[26:25], u_wlm_ctrl_model.WCL_CODE, "extra latency");
		apb(1'b0, wlm_pkg::ADDR_MR2, 32'h0, rd, err);
		check(rd, 32'(lastMr2), "mr2 shadow");
		mrsw(wlm_pkg::SEL_MR2, lastMr2 | 18'h02000, 1'b1);
		check(reservedBitError, 32'h1, "reserved set");
		apb(1'b1, wlm_pkg::ADDR_STATUS, 32'h80000000, rd, err);
		@(posedge clock);
		check(reservedBitError, 32'h0, "reserved clear");
		$display("test hold and reserved done");
		conclude();
	end
endmodule : wlm_write_latency_mode_config_tb_top
`default_nettype wire
